// file: pfta_mem_model.sv
// Behavioural program memory and configuration space behind the sequencer.
`timescale 1ns/10ps
module pfta_mem_model (
  input wire logic [20:0] i_addr,
  output logic [15:0] o_word,
  output logic [7:0] o_cfg
);
  // Both bytes of a word differ, so a wrong byte lane cannot pass unseen.
  assign o_word = {i_addr[8:1] ^ 8'h5a, i_addr[8:1]};
  assign o_cfg = i_addr[7:0] ^ 8'h3c;
endmodule

// file: pfta_pkg.sv
// Package with constants and carriers for the program flash table access.
// Summary of operation
// - Three pointer bytes form one 22-bit byte address; low 21 bits address.
// - Pointer bit 21 set sends table accesses to configuration space.
// - Table operations keep, post-inc, post-dec or pre-inc the pointer.
// - Automatic pointer updates touch only the low 21 bits; bit 21 stays.
// - A table read uses all 22 pointer bits to load one byte into the latch.
// - Table write copies latch into the holding register picked by bits 2:0.
// - Programming long write targets the 8-byte block at pointer bits 21:3.
// - A row erase clears the 64-byte block given by pointer bits 21:6.
// - Memory holds 16-bit words; address bit 0 picks low or high byte.
// - A row erase ignores the table latch contents.
// - Execution halts for the whole long write, ended by an internal timer.
// - A row erase stalls the core for about 2 ms.
// - Self erase works only on whole 64-byte rows.
// - Programming works only on whole 8-byte blocks.
// - Start cannot be set while the modify permit bit is clear.
// - Only the core sets start; the device clears it on completion.
// - Completion flag is set when the write completes; the core clears it.
package pfta_pkg;
  localparam int PTR_W = 22;
  localparam int ADDR_W = 21;
  localparam int CFG_BIT = 21;
  localparam int HOLD_N = 8;
  localparam int HOLD_SEL_W = 3;
  localparam int ROW_LSB = 6;
  localparam int BLK_LSB = 3;
  localparam logic [7:0] KEY_FIRST = 8'h55;
  localparam logic [7:0] KEY_SECOND = 8'haa;
  localparam logic [PTR_W-1:0] PTR_RESET = 22'h000000;
  localparam logic [7:0] LATCH_RESET = 8'h00;
  localparam int CLK_HZ = 10_000_000;
  localparam int LONG_WRITE_US = 2000;
  localparam int LONG_WRITE_CYCLES = LONG_WRITE_US * (CLK_HZ / 1_000_000);

  typedef enum logic [1:0] {
    PFTA_PTR_KEEP,
    PFTA_PTR_POST_INC,
    PFTA_PTR_POST_DEC,
    PFTA_PTR_PRE_INC
  } pfta_ptr_mode_t;

  typedef struct packed {
    logic rd;
    logic wr;
    pfta_ptr_mode_t mode;
  } pfta_table_op_t;

  typedef struct packed {
    logic program_space_select;
    logic config_space_select;
    logic row_erase_select;
    logic modify_permit;
  } pfta_ctrl_t;

  typedef struct packed {
    logic erase;
    logic cfg;
    logic [ADDR_W-1:0] addr;
  } pfta_flash_cmd_t;
endpackage

// file: pfta_sequencer.sv
// Table pointer, table latch, holding registers and long write sequencer.
`timescale 1ns/10ps
module pfta_sequencer #(
  parameter int LONG_CYCLES = pfta_pkg::LONG_WRITE_CYCLES
) (
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  input wire logic [2:0] i_ptr_byte_we,
  input wire logic [7:0] i_ptr_byte_wdata,
  input wire logic i_latch_we,
  input wire logic [7:0] i_latch_wdata,
  input wire pfta_pkg::pfta_table_op_t i_table_op,
  input wire logic i_key_we,
  input wire logic [7:0] i_key_wdata,
  input wire logic i_other_we,
  input wire logic i_start_set,
  input wire pfta_pkg::pfta_ctrl_t i_ctrl,
  input wire logic i_flag_clear,
  input wire logic [15:0] i_mem_word,
  input wire logic [7:0] i_cfg_byte,
  output logic [pfta_pkg::PTR_W-1:0] o_table_pointer,
  output logic [7:0] o_table_latch,
  output logic [pfta_pkg::ADDR_W-1:0] o_mem_addr,
  output logic o_mem_cfg,
  output logic o_start,
  output logic o_stall,
  output logic o_completion_flag,
  output pfta_pkg::pfta_flash_cmd_t o_flash_cmd,
  output logic o_flash_cmd_valid,
  output logic [63:0] o_hold_data
);
  localparam int PW = pfta_pkg::PTR_W;
  localparam int AW = pfta_pkg::ADDR_W;

  if (LONG_CYCLES < 2) begin : g_bad_cycles
    $error("pfta_sequencer: LONG_CYCLES must be at least 2");
  end

  logic [PW-1:0] table_pointer;
  logic [PW-1:0] next_table_pointer;
  logic [PW-1:0] access_ptr;
  logic [7:0] table_latch;
  logic [7:0] next_table_latch;
  logic [7:0] hold [pfta_pkg::HOLD_N];
  logic [1:0] key_state;
  logic [1:0] next_key_state;
  logic start;
  logic next_start;
  logic flag;
  logic next_flag;
  logic erase_op;
  logic next_erase_op;
  logic cmd_valid;
  logic next_cmd_valid;
  pfta_pkg::pfta_flash_cmd_t flash_cmd;
  pfta_pkg::pfta_flash_cmd_t next_flash_cmd;
  logic go;
  logic timer_busy;
  logic timer_done;
  logic [7:0] read_byte;

  // Pointer as seen by the current table operation; pre-increment applies first.
  always_comb begin
    access_ptr = table_pointer;
    if (i_table_op.mode == pfta_pkg::PFTA_PTR_PRE_INC) begin
      access_ptr[AW-1:0] = table_pointer[AW-1:0] + 1'b1;
    end
  end

  // Memory address presented combinationally so the byte returns the same cycle.
  assign o_mem_addr = access_ptr[AW-1:0];
  assign o_mem_cfg = access_ptr[pfta_pkg::CFG_BIT];

  always_comb begin
    if (access_ptr[pfta_pkg::CFG_BIT]) begin
      read_byte = i_cfg_byte;
    end else if (access_ptr[0]) begin
      read_byte = i_mem_word[15:8];
    end else begin
      read_byte = i_mem_word[7:0];
    end
  end

  always_comb begin
    next_table_pointer = table_pointer;
    next_table_latch = table_latch;
    // The upper byte is only six bits wide, so it is loaded on its own below.
    for (int b = 0; b < 2; b++) begin
      if (i_ptr_byte_we[b]) begin
        next_table_pointer[b*8 +: 8] = i_ptr_byte_wdata;
      end
    end
    next_table_pointer[PW-1] = next_table_pointer[PW-1] & ~i_ptr_byte_we[2];
    if (i_ptr_byte_we[2]) begin
      next_table_pointer[PW-1:16] = i_ptr_byte_wdata[5:0];
    end
    if (i_latch_we) begin
      next_table_latch = i_latch_wdata;
    end
    if ((i_table_op.rd || i_table_op.wr) && !timer_busy) begin
      case (i_table_op.mode)
        pfta_pkg::PFTA_PTR_POST_INC: begin
          next_table_pointer[AW-1:0] = table_pointer[AW-1:0] + 1'b1;
        end
        pfta_pkg::PFTA_PTR_POST_DEC: begin
          next_table_pointer[AW-1:0] = table_pointer[AW-1:0] - 1'b1;
        end
        pfta_pkg::PFTA_PTR_PRE_INC: begin
          next_table_pointer = access_ptr;
        end
        default: begin
          next_table_pointer = table_pointer;
        end
      endcase
      if (i_table_op.rd) begin
        next_table_latch = read_byte;
      end
    end
  end

  // Holding registers: one per low pointer value, loaded by table writes.
  genvar g;
  generate
    for (g = 0; g < pfta_pkg::HOLD_N; g++) begin : g_hold
      always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
          hold[g] <= 8'h00;
        end else if (i_table_op.wr && !timer_busy &&
                     access_ptr[pfta_pkg::HOLD_SEL_W-1:0] == 3'(g)) begin
          hold[g] <= table_latch;
        end
      end
      assign o_hold_data[g*8 +: 8] = hold[g];
    end
  endgenerate

  // Unlock keys: an i_other_we write or a table read or write between steps breaks the sequence; pointer and latch writes do not.
  always_comb begin
    next_key_state = key_state;
    go = 1'b0;
    if (i_start_set) begin
      go = (key_state == 2'd2) && i_ctrl.modify_permit && !start;
      next_key_state = 2'd0;
    end else if (i_key_we) begin
      if (i_key_wdata == pfta_pkg::KEY_FIRST) begin
        next_key_state = 2'd1;
      end else if (i_key_wdata == pfta_pkg::KEY_SECOND &&
                   key_state == 2'd1) begin
        next_key_state = 2'd2;
      end else begin
        next_key_state = 2'd0;
      end
    end else if (i_other_we || i_table_op.rd || i_table_op.wr) begin
      next_key_state = 2'd0;
    end
  end

  always_comb begin
    next_start = start;
    next_erase_op = erase_op;
    next_cmd_valid = 1'b0;
    next_flash_cmd = flash_cmd;
    next_flag = flag;
    if (i_flag_clear) begin
      next_flag = 1'b0;
    end
    if (go) begin
      next_start = 1'b1;
      next_erase_op = i_ctrl.row_erase_select;
      next_cmd_valid = 1'b1;
      next_flash_cmd.cfg = table_pointer[pfta_pkg::CFG_BIT];
      next_flash_cmd.erase = i_ctrl.row_erase_select;
      if (i_ctrl.row_erase_select) begin
        next_flash_cmd.addr = {table_pointer[AW-1:pfta_pkg::ROW_LSB],
                               6'h00};
      end else begin
        next_flash_cmd.addr = {table_pointer[AW-1:pfta_pkg::BLK_LSB],
                               3'h0};
      end
    end
    if (timer_done) begin
      next_start = 1'b0;
      next_erase_op = 1'b0;
      next_flag = 1'b1;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      table_pointer <= pfta_pkg::PTR_RESET;
      table_latch <= pfta_pkg::LATCH_RESET;
      key_state <= 2'd0;
      start <= 1'b0;
      flag <= 1'b0;
      erase_op <= 1'b0;
      cmd_valid <= 1'b0;
      flash_cmd <= '0;
    end else begin
      table_pointer <= next_table_pointer;
      table_latch <= next_table_latch;
      key_state <= next_key_state;
      start <= next_start;
      flag <= next_flag;
      erase_op <= next_erase_op;
      cmd_valid <= next_cmd_valid;
      flash_cmd <= next_flash_cmd;
    end
  end

  pfta_timer #(
    .CYCLES(LONG_CYCLES)
  ) u_timer (
    .i_clk_sys(i_clk_sys),
    .i_rst_n(i_rst_n),
    .i_start(go),
    .o_busy(timer_busy),
    .o_done(timer_done)
  );

  assign o_table_pointer = table_pointer;
  assign o_table_latch = table_latch;
  assign o_start = start;
  assign o_stall = start;
  assign o_completion_flag = flag;
  assign o_flash_cmd = flash_cmd;
  assign o_flash_cmd_valid = cmd_valid;
endmodule

// file: pfta_sequencer_asserts.sv
// Concurrent checks on the ports of the table access sequencer.
`timescale 1ns/10ps
module pfta_sequencer_asserts #(
  parameter int LONG_CYCLES = 8
) (
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  input wire pfta_pkg::pfta_table_op_t i_table_op,
  input wire logic i_start_set,
  input wire pfta_pkg::pfta_ctrl_t i_ctrl,
  input wire logic [15:0] i_mem_word,
  input wire logic [7:0] i_cfg_byte,
  input wire logic [21:0] o_table_pointer,
  input wire logic [7:0] o_table_latch,
  input wire logic [20:0] o_mem_addr,
  input wire logic o_mem_cfg,
  input wire logic o_start,
  input wire logic o_stall,
  input wire logic o_completion_flag,
  input wire pfta_pkg::pfta_flash_cmd_t o_flash_cmd,
  input wire logic o_flash_cmd_valid
);
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_n);
  logic rd_go;
  logic [7:0] rd_byte;
  logic [21:0] ptr_inc;
  int run;
  int next_run;
  assign rd_go = i_table_op.rd && !o_start;
  assign rd_byte = o_mem_cfg ? i_cfg_byte :
                   (o_mem_addr[0] ? i_mem_word[15:8] : i_mem_word[7:0]);
  assign ptr_inc = {o_table_pointer[21], o_table_pointer[20:0] + 21'h1};
  always_comb next_run = o_start ? run + 1 : 0;
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) run <= 0;
    else run <= next_run;
  end
  sequence start_seen;
    $rose(o_start);
  endsequence
  sequence cmd_pulse;
    o_flash_cmd_valid ##1 !o_flash_cmd_valid;
  endsequence
  permit_gate_a: assert property (start_seen |-> $past(i_start_set) &&
    $past(i_ctrl.modify_permit)) else $error("start without permit");
  stall_tie_a: assert property (o_stall == o_start)
    else $error("stall differs from start");
  cmd_once_a: assert property (start_seen |-> cmd_pulse)
    else $error("command pulse wrong");
  erase_row_a: assert property ((start_seen and o_flash_cmd.erase) |->
    o_flash_cmd.addr == {$past(o_table_pointer[20:6]), 6'h0})
    else $error("erase row address wrong");
  prog_addr_a: assert property ((start_seen and !o_flash_cmd.erase) |->
    o_flash_cmd.addr == {$past(o_table_pointer[20:3]), 3'h0})
    else $error("program block address wrong");
  stall_len_a: assert property ($fell(o_start) |->
    run == LONG_CYCLES + 1) else $error("stall length wrong");
  done_flag_a: assert property ($fell(o_start) |-> o_completion_flag)
    else $error("flag not set at completion");
  ptr_inc_a: assert property (rd_go && i_table_op.mode ==
    pfta_pkg::PFTA_PTR_POST_INC |=> o_table_pointer == $past(ptr_inc))
    else $error("post increment wrong");
  latch_load_a: assert property (rd_go |=>
    o_table_latch == $past(rd_byte)) else $error("latch not loaded");
  read_addr_a: assert property (rd_go |->
    o_mem_cfg == o_table_pointer[21] &&
    o_mem_addr == (i_table_op.mode == pfta_pkg::PFTA_PTR_PRE_INC ?
    ptr_inc[20:0] : o_table_pointer[20:0])) else $error("read address wrong");
endmodule

// file: pfta_timer.sv
// Self-timed programming timer for long writes.
`timescale 1ns/10ps
module pfta_timer #(
  parameter int CYCLES = pfta_pkg::LONG_WRITE_CYCLES
) (
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  input wire logic i_start,
  output logic o_busy,
  output logic o_done
);
  localparam int CW = $clog2(CYCLES + 1);
  logic [CW-1:0] count;
  logic [CW-1:0] next_count;
  logic busy;
  logic next_busy;
  logic done;
  logic next_done;

  // A shorter span would leave no cycle between start and done.
  if (CYCLES < 2) begin : g_bad_cycles
    $error("pfta_timer: CYCLES must be at least 2");
  end

  always_comb begin
    next_count = count;
    next_busy = busy;
    next_done = 1'b0;
    if (!busy && i_start) begin
      next_busy = 1'b1;
      next_count = CW'(CYCLES - 1);
    end else if (busy) begin
      if (count == '0) begin
        next_busy = 1'b0;
        next_done = 1'b1;
      end else begin
        next_count = count - 1'b1;
      end
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      count <= '0;
      busy <= 1'b0;
      done <= 1'b0;
    end else begin
      count <= next_count;
      busy <= next_busy;
      done <= next_done;
    end
  end

  assign o_busy = busy;
  assign o_done = done;
endmodule

// file: tb.sv
// Self-checking bench for the table access sequencer.
`timescale 1ns/10ps
module tb;
  localparam int LC = 8;
  logic i_clk_sys = 1'b0, i_rst_n = 1'b0, i_latch_we = 1'b0, i_key_we = 1'b0;
  logic i_other_we = 1'b0, i_start_set = 1'b0, i_flag_clear = 1'b0;
  logic [2:0] i_ptr_byte_we = 3'h0;
  logic [7:0] i_ptr_byte_wdata = 8'h00, i_latch_wdata = 8'h00;
  logic [7:0] i_key_wdata = 8'h00, i_cfg_byte, o_table_latch;
  pfta_pkg::pfta_table_op_t i_table_op = '0;
  pfta_pkg::pfta_ctrl_t i_ctrl = '0;
  pfta_pkg::pfta_flash_cmd_t o_flash_cmd;
  logic [15:0] i_mem_word;
  logic [21:0] o_table_pointer;
  logic [20:0] o_mem_addr;
  logic o_mem_cfg, o_start, o_stall, o_completion_flag, o_flash_cmd_valid;
  logic [63:0] o_hold_data;
  int miscompares = 0;
  int check_count = 0;
  pfta_sequencer #(.LONG_CYCLES(LC)) dut_u (.i_clk_sys, .i_rst_n,
    .i_ptr_byte_we, .i_ptr_byte_wdata, .i_latch_we, .i_latch_wdata,
    .i_table_op, .i_key_we, .i_key_wdata, .i_other_we, .i_start_set, .i_ctrl,
    .i_flag_clear, .i_mem_word, .i_cfg_byte, .o_table_pointer, .o_table_latch,
    .o_mem_addr, .o_mem_cfg, .o_start, .o_stall, .o_completion_flag,
    .o_flash_cmd, .o_flash_cmd_valid, .o_hold_data);
  pfta_mem_model mem_u (.i_addr(o_mem_addr), .o_word(i_mem_word),
    .o_cfg(i_cfg_byte));
  initial forever #50 i_clk_sys = ~i_clk_sys;
  function automatic logic [7:0] mbyte(input logic [21:0] a);
    if (a[21]) return a[7:0] ^ 8'h3c;
    return a[0] ? (a[8:1] ^ 8'h5a) : a[8:1];
  endfunction
  task automatic tick(input int n = 1);
    repeat (n) @(posedge i_clk_sys);
    #10;
  endtask
  task automatic chk(input string nm, input logic [63:0] seen, exp);
    check_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic setp(input logic [21:0] p);
    logic [23:0] q = {2'h0, p};
    for (int i = 0; i < 3; i++) begin
      i_ptr_byte_we = 3'h1 << i;
      i_ptr_byte_wdata = q[i*8 +: 8];
      tick();
    end
    i_ptr_byte_we = 3'h0;
  endtask
  task automatic op(input logic rd, input logic [1:0] m);
    i_table_op = '{rd, ~rd, pfta_pkg::pfta_ptr_mode_t'(m)};
    tick();
    i_table_op = '0;
  endtask
  task automatic rdchk(input logic [1:0] m, input logic [21:0] a, np);
    op(1'b1, m);
    chk("latch", 64'(o_table_latch), 64'(mbyte(a)));
    chk("pointer", 64'(o_table_pointer), 64'(np));
    tick();
  endtask
  task automatic go(input logic [7:0] k1, k2, input logic oth, perm, ers,
                    input logic ex, input logic [20:0] a);
    int n = 0;
    i_ctrl = '{1'b1, 1'b0, ers, perm};
    i_key_we = 1'b1;
    i_key_wdata = k1;
    tick();
    i_key_we = 1'b0;
    i_other_we = oth;
    tick();
    i_other_we = 1'b0;
    i_key_we = 1'b1;
    i_key_wdata = k2;
    tick();
    i_key_we = 1'b0;
    i_start_set = 1'b1;
    tick();
    i_start_set = 1'b0;
    chk("start", 64'(o_start), 64'(ex));
    if (ex) begin
      chk("command", 64'(o_flash_cmd), 64'({ers, 1'b0, a}));
      while (o_start === 1'b1 && n < 4 * LC) begin
        tick();
        n++;
      end
      chk("stall span", 64'(n), 64'(LC + 1));
      tick();
      chk("flag", 64'(o_completion_flag), 64'h1);
      i_flag_clear = 1'b1;
      tick();
      i_flag_clear = 1'b0;
      chk("flag clear", 64'(o_completion_flag), 64'h0);
    end
    $display("Start attempt done");
  endtask
  task automatic end_sim;
    $display("Checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  initial begin
    #100_000;
    miscompares++;
    end_sim();
  end
  task automatic read_test;
    setp(22'h000101);
    rdchk(2'd1, 22'h000101, 22'h000102);
    rdchk(2'd3, 22'h000103, 22'h000103);
    rdchk(2'd2, 22'h000103, 22'h000102);
    rdchk(2'd0, 22'h000102, 22'h000102);
    setp(22'h3fffff);
    rdchk(2'd1, 22'h3fffff, 22'h200000);
    $display("Read test done");
  endtask
  task automatic hold_test;
    setp(22'h000047);
    for (int k = 0; k < 8; k++) begin
      i_latch_we = 1'b1;
      i_latch_wdata = 8'h10 + 8'(k);
      tick();
      i_latch_we = 1'b0;
      op(1'b0, 2'd3);
    end
    chk("hold", o_hold_data, 64'h1716151413121110);
    $display("Hold test done");
  endtask
  initial begin
    tick(3);
    i_rst_n = 1'b1;
    tick();
    read_test();
    hold_test();
    go(8'h55, 8'haa, 1'b0, 1'b1, 1'b0, 1'b1, 21'h000048);
    setp(22'h0001ff);
    go(8'h55, 8'haa, 1'b0, 1'b1, 1'b1, 1'b1, 21'h0001c0);
    go(8'h55, 8'haa, 1'b0, 1'b0, 1'b1, 1'b0, 21'h0);
    go(8'h55, 8'haa, 1'b1, 1'b1, 1'b1, 1'b0, 21'h0);
    go(8'haa, 8'h55, 1'b0, 1'b1, 1'b1, 1'b0, 21'h0);
    end_sim();
  end
endmodule
bind pfta_sequencer pfta_sequencer_asserts #(.LONG_CYCLES(LONG_CYCLES)) chk_u (
  .i_clk_sys, .i_rst_n, .i_table_op, .i_start_set, .i_ctrl, .i_mem_word,
  .i_cfg_byte, .o_table_pointer, .o_table_latch, .o_mem_addr, .o_mem_cfg,
  .o_start, .o_stall, .o_completion_flag, .o_flash_cmd, .o_flash_cmd_valid);
